// File: sas_defs.svh
// Register map, field positions and timing counts for the SAR sequencer.
// Assumes a 100 MHz aclk that also serves as the oscillator clock.
// Summary of operation
// - With RC clock chosen, one instruction cycle passes before it ticks.
// - Software picks supply rails or external pins as references.
// - On completion: load result pair, clear start bit 1, set flag.
// - Reset returns registers to defaults, module off, conversion aborted.
// - Reset leaves the result pair untouched.
// - Two conversion clock periods of idle follow every conversion.
// - Sampling switch opens the moment conversion begins.
// - Acquisition field zero: start bit begins conversion at once.
// - Nonzero field: keep sampling programmed periods, then convert.
// - After conversion sampling resumes; no phase status is shown.
// - A conversion lasts eleven conversion clock periods: one to load the trial code, then one per bit.
// - Clock field maps to divisors 2,4,8,16,32,64 or RC clock.
// - RC conversion clock period is about four microseconds.
// - Clearing the start bit aborts; result pair keeps old value.
// - Acquisition field 010 gives four periods of acquisition.
`ifndef SAS_DEFS_SVH
`define SAS_DEFS_SVH

`define SAS_AW 8
`define SAS_OFF_CTRL0 8'h00
`define SAS_OFF_CTRL1 8'h04
`define SAS_OFF_CTRL2 8'h08
`define SAS_OFF_RES_HI 8'h0c
`define SAS_OFF_RES_LO 8'h10
`define SAS_OFF_IRQ 8'h14

`define SAS_CTRL0_EN 0
`define SAS_CTRL0_GO 1
`define SAS_CTRL0_CH_LSB 2
`define SAS_CTRL1_PCFG_LSB 0
`define SAS_CTRL1_VREF_LSB 4
`define SAS_CTRL2_CLK_LSB 0
`define SAS_CTRL2_ACQ_LSB 3
`define SAS_CTRL2_JUST 7
`define SAS_IRQ_FLAG 0
`define SAS_IRQ_EN 1

`define SAS_RESP_OKAY 2'b00
`define SAS_RESP_SLVERR 2'b10

`define SAS_CLK_NS 10
`define SAS_RC_PERIOD_NS 4000
`define SAS_RC_CYC (`SAS_RC_PERIOD_NS / `SAS_CLK_NS)
`define SAS_INSTR_OSC 4
`define SAS_RES_BITS 10
`define SAS_CONV_TADS 11
`define SAS_WAIT_TADS 2
`define SAS_ACQ_TABLE {5'd20, 5'd16, 5'd12, 5'd8, 5'd6, 5'd4, 5'd2, 5'd0}
`define SAS_DIV_TABLE {7'd0, 7'd64, 7'd16, 7'd4, 7'd0, 7'd32, 7'd8, 7'd2}

`endif

// File: sas_pkg.sv
// Types shared by the SAR sequencer modules.
// Assumes nothing of its surroundings.
package sas_pkg;

    typedef enum logic [3:0] {
        SAS_IDLE = 4'b0001,
        SAS_ACQ = 4'b0010,
        SAS_CONV = 4'b0100,
        SAS_WAIT = 4'b1000
    } sas_state_e;

    typedef struct packed {
        logic [3:0] chan;
        logic go;
        logic en;
    } sas_ctrl0_s;

    typedef struct packed {
        logic just;
        logic [2:0] acq;
        logic [2:0] clk;
    } sas_ctrl2_s;

endpackage

// File: sas_tad_gen.sv
// Conversion clock tick generator: oscillator divisor or RC period.
// Assumes run stays high for the whole span that needs ticks.
`timescale 1ns/100ps
`include "sas_defs.svh"
module sas_tad_gen #(
    parameter int RC_CYC = `SAS_RC_CYC,
    parameter int DLY_CYC = `SAS_INSTR_OSC
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // Control
    input wire logic run,
    input wire logic [2:0] clk_sel,
    // Tick out
    output logic tick
);
    localparam logic [55:0] DIVS = `SAS_DIV_TABLE;
    logic [15:0] cnt_ff;
    logic run_d_ff;
    logic rc;
    logic [15:0] limit;

    assign rc = (clk_sel[1:0] == 2'b11);
    always_comb begin
        limit = 16'(RC_CYC);
        if (!rc) begin
            limit = {9'h000, DIVS[7*clk_sel +: 7]};
        end
    end

    assign tick = ce && run && run_d_ff && (cnt_ff == 16'h0000);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_ff <= 16'h0000;
            run_d_ff <= 1'b0;
        end else if (ce) begin
            run_d_ff <= run;
            if (!run) begin
                cnt_ff <= 16'h0000;
            end else if (!run_d_ff) begin
                cnt_ff <= rc ? limit - 16'h0001 + 16'(DLY_CYC)
                             : limit - 16'h0001;
            end else if (cnt_ff == 16'h0000) begin
                cnt_ff <= limit - 16'h0001;
            end else begin
                cnt_ff <= cnt_ff - 16'h0001;
            end
        end
    end

    AST_RC_DELAY: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && run && !run_d_ff && rc) |=> !tick [*4])
        else $error("RC clock ticked inside the start delay");
endmodule

// File: sas_sar_reg.sv
// Successive approximation register driving the DAC trial code.
// Assumes cmp_hi is valid when step is high.
`timescale 1ns/100ps
module sas_sar_reg #(
    parameter int W = 10
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // Sequencing
    input wire logic start,
    input wire logic step,
    input wire logic cmp_hi,
    // Trial code
    output logic [W-1:0] code
);
    logic [W-1:0] mask_ff;
    logic [W-1:0] code_ff;
    logic [W-1:0] kept;

    assign code = code_ff;
    assign kept = cmp_hi ? code_ff : (code_ff & ~mask_ff);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mask_ff <= '0;
            code_ff <= '0;
        end else if (ce) begin
            if (start) begin
                mask_ff <= {1'b1, {(W-1){1'b0}}};
                code_ff <= {1'b1, {(W-1){1'b0}}};
            end else if (step) begin
                // One bit decided per step
                mask_ff <= mask_ff >> 1;
                code_ff <= kept | (mask_ff >> 1);
            end
        end
    end
endmodule

// File: sas_top.sv
// SAR converter sequencer with AXI4-Lite register access.
// Assumes a comparator output cmp_hi that is synchronous to aclk.
//
// The AXI4-Lite interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/100ps
`include "sas_defs.svh"
module sas_top #(
    parameter int RC_CYC = `SAS_RC_CYC
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // AXI4-Lite write
    input wire logic awvalid,
    output logic awready,
    input wire logic [`SAS_AW-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read
    input wire logic arvalid,
    output logic arready,
    input wire logic [`SAS_AW-1:0] araddr,
    input wire logic [2:0] arprot,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // Analog front end
    input wire logic cmp_hi,
    output logic sample_on,
    output logic [9:0] dac_code,
    output logic [3:0] chan_sel,
    output logic [3:0] pin_cfg,
    output logic [1:0] vref_sel
);
    import sas_pkg::*;

    localparam logic [39:0] ACQ_TAB = `SAS_ACQ_TABLE;

    sas_ctrl0_s ctrl0_ff;
    logic [5:0] ctrl1_ff;
    sas_ctrl2_s ctrl2_ff;
    logic [7:0] res_hi_ff;
    logic [7:0] res_lo_ff;
    logic flag_ff;
    logic irq_en_ff;

    logic awready_ff;
    logic wready_ff;
    logic aw_got_ff;
    logic w_got_ff;
    logic [`SAS_AW-1:0] waddr_ff;
    logic [7:0] wbyte_ff;
    logic wlane_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic arready_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;

    sas_state_e state_ff;
    logic [4:0] acq_cnt_ff;
    logic [3:0] conv_cnt_ff;
    logic [1:0] wait_cnt_ff;
    logic done_ff;
    logic sample_on_ff;

    logic tick;
    logic wr_fire;
    logic wr_en;
    logic wr_hit;
    logic [31:0] rd_val;
    logic rd_hit;
    logic live;
    logic conv_start;
    logic sar_start;
    logic sar_step;
    logic [9:0] sar_code;
    logic [9:0] nxt_res;

    assign awready = awready_ff;
    assign wready = wready_ff;
    assign bvalid = bvalid_ff;
    assign bresp = bresp_ff;
    assign arready = arready_ff;
    assign rvalid = rvalid_ff;
    assign rdata = rdata_ff;
    assign rresp = rresp_ff;
    assign sample_on = sample_on_ff;
    assign dac_code = sar_code;
    assign chan_sel = ctrl0_ff.chan;
    assign pin_cfg = ctrl1_ff[`SAS_CTRL1_PCFG_LSB +: 4];
    assign vref_sel = ctrl1_ff[`SAS_CTRL1_VREF_LSB +: 2];

    // Write address and data are taken in either order
    assign wr_fire = aw_got_ff && w_got_ff && !bvalid_ff;
    assign wr_en = wr_fire && wlane_ff && wr_hit;

    always_comb begin
        case (waddr_ff)
            `SAS_OFF_CTRL0, `SAS_OFF_CTRL1, `SAS_OFF_CTRL2,
            `SAS_OFF_RES_HI, `SAS_OFF_RES_LO, `SAS_OFF_IRQ: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= `SAS_RESP_OKAY;
            waddr_ff <= '0;
            wbyte_ff <= 8'h00;
            wlane_ff <= 1'b0;
        end else if (ce) begin
            if (awvalid && awready_ff) begin
                waddr_ff <= awaddr;
                aw_got_ff <= 1'b1;
                awready_ff <= 1'b0;
            end
            if (wvalid && wready_ff) begin
                wbyte_ff <= wdata[7:0];
                wlane_ff <= wstrb[0];
                w_got_ff <= 1'b1;
                wready_ff <= 1'b0;
            end
            if (wr_fire) begin
                bvalid_ff <= 1'b1;
                bresp_ff <= wr_hit ? `SAS_RESP_OKAY : `SAS_RESP_SLVERR;
                aw_got_ff <= 1'b0;
                w_got_ff <= 1'b0;
            end
            if (bvalid_ff && bready) begin
                bvalid_ff <= 1'b0;
                awready_ff <= 1'b1;
                wready_ff <= 1'b1;
            end
        end
    end

    // Read data are captured when the address is taken
    always_comb begin
        rd_hit = 1'b1;
        rd_val = 32'h0000_0000;
        case (araddr)
            `SAS_OFF_CTRL0: rd_val = {26'h0, ctrl0_ff};
            `SAS_OFF_CTRL1: rd_val = {26'h0, ctrl1_ff};
            `SAS_OFF_CTRL2: rd_val = {24'h0, ctrl2_ff.just, 1'b0,
                                      ctrl2_ff.acq, ctrl2_ff.clk};
            `SAS_OFF_RES_HI: rd_val = {24'h0, res_hi_ff};
            `SAS_OFF_RES_LO: rd_val = {24'h0, res_lo_ff};
            `SAS_OFF_IRQ: rd_val = {30'h0, irq_en_ff, flag_ff};
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= `SAS_RESP_OKAY;
        end else if (ce) begin
            if (arvalid && arready_ff) begin
                arready_ff <= 1'b0;
                rvalid_ff <= 1'b1;
                rdata_ff <= rd_val;
                rresp_ff <= rd_hit ? `SAS_RESP_OKAY : `SAS_RESP_SLVERR;
            end else if (rvalid_ff && rready) begin
                rvalid_ff <= 1'b0;
                arready_ff <= 1'b1;
            end
        end
    end

    // Control registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl0_ff <= '0;
            ctrl1_ff <= 6'h00;
            ctrl2_ff <= '0;
            irq_en_ff <= 1'b0;
        end else if (ce) begin
            if (wr_en && waddr_ff == `SAS_OFF_CTRL0) begin
                ctrl0_ff.en <= wbyte_ff[`SAS_CTRL0_EN];
                ctrl0_ff.chan <= wbyte_ff[`SAS_CTRL0_CH_LSB +: 4];
                // Start only takes on an already enabled module
                ctrl0_ff.go <= wbyte_ff[`SAS_CTRL0_GO] &&
                               wbyte_ff[`SAS_CTRL0_EN] && ctrl0_ff.en;
            end else if (done_ff) begin
                ctrl0_ff.go <= 1'b0;
            end
            if (wr_en && waddr_ff == `SAS_OFF_CTRL1) begin
                ctrl1_ff <= wbyte_ff[5:0];
            end
            if (wr_en && waddr_ff == `SAS_OFF_CTRL2) begin
                ctrl2_ff.just <= wbyte_ff[`SAS_CTRL2_JUST];
                ctrl2_ff.acq <= wbyte_ff[`SAS_CTRL2_ACQ_LSB +: 3];
                ctrl2_ff.clk <= wbyte_ff[`SAS_CTRL2_CLK_LSB +: 3];
            end
            if (wr_en && waddr_ff == `SAS_OFF_IRQ) begin
                irq_en_ff <= wbyte_ff[`SAS_IRQ_EN];
            end
        end
    end

    // Completion flag: a set in the clearing cycle wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flag_ff <= 1'b0;
        end else if (ce) begin
            if (done_ff) begin
                flag_ff <= 1'b1;
            end else if (wr_en && waddr_ff == `SAS_OFF_IRQ &&
                         wbyte_ff[`SAS_IRQ_FLAG]) begin
                flag_ff <= 1'b0;
            end
        end
    end

    // Result pair has no reset so that its content survives a reset
    always_comb begin
        nxt_res = sar_code;
    end

    always_ff @(posedge aclk) begin
        if (ce) begin
            if (done_ff) begin
                if (ctrl2_ff.just) begin
                    res_hi_ff <= {6'h00, nxt_res[9:8]};
                    res_lo_ff <= nxt_res[7:0];
                end else begin
                    res_hi_ff <= nxt_res[9:2];
                    res_lo_ff <= {nxt_res[1:0], 6'h00};
                end
            end else if (wr_en && waddr_ff == `SAS_OFF_RES_HI) begin
                res_hi_ff <= wbyte_ff;
            end else if (wr_en && waddr_ff == `SAS_OFF_RES_LO) begin
                res_lo_ff <= wbyte_ff;
            end
        end
    end

    // Sequencer
    assign live = ctrl0_ff.en && ctrl0_ff.go;
    assign conv_start = (state_ff == SAS_IDLE && live &&
                         ctrl2_ff.acq == 3'b000) ||
                        (state_ff == SAS_ACQ && live && tick &&
                         acq_cnt_ff == 5'd1);
    assign sar_start = state_ff == SAS_CONV && live && tick &&
                       conv_cnt_ff == 4'd0;
    assign sar_step = state_ff == SAS_CONV && live && tick &&
                      conv_cnt_ff != 4'd0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= SAS_IDLE;
            acq_cnt_ff <= 5'd0;
            conv_cnt_ff <= 4'd0;
            wait_cnt_ff <= 2'd0;
            done_ff <= 1'b0;
        end else if (ce) begin
            done_ff <= 1'b0;
            if (!ctrl0_ff.en) begin
                state_ff <= SAS_IDLE;
            end else begin
                case (state_ff)
                    SAS_IDLE: begin
                        if (conv_start) begin
                            state_ff <= SAS_CONV;
                            conv_cnt_ff <= 4'd0;
                        end else if (live) begin
                            state_ff <= SAS_ACQ;
                            acq_cnt_ff <= ACQ_TAB[5*ctrl2_ff.acq +: 5];
                        end
                    end
                    SAS_ACQ: begin
                        if (!ctrl0_ff.go) begin
                            state_ff <= SAS_WAIT;
                            wait_cnt_ff <= 2'd0;
                        end else if (conv_start) begin
                            state_ff <= SAS_CONV;
                            conv_cnt_ff <= 4'd0;
                        end else if (tick) begin
                            acq_cnt_ff <= acq_cnt_ff - 5'd1;
                        end
                    end
                    SAS_CONV: begin
                        if (!ctrl0_ff.go) begin
                            state_ff <= SAS_WAIT;
                            wait_cnt_ff <= 2'd0;
                        end else if (tick) begin
                            conv_cnt_ff <= conv_cnt_ff + 4'd1;
                            if (conv_cnt_ff == 4'(`SAS_CONV_TADS - 1)) begin
                                state_ff <= SAS_WAIT;
                                wait_cnt_ff <= 2'd0;
                                done_ff <= 1'b1;
                            end
                        end
                    end
                    SAS_WAIT: begin
                        if (tick) begin
                            wait_cnt_ff <= wait_cnt_ff + 2'd1;
                            if (wait_cnt_ff == 2'(`SAS_WAIT_TADS - 1)) begin
                                state_ff <= SAS_IDLE;
                            end
                        end
                    end
                    default: state_ff <= SAS_IDLE;
                endcase
            end
        end
    end

    // Sampling switch closed while enabled and idle or acquiring, open from conversion
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sample_on_ff <= 1'b0;
        end else if (ce) begin
            sample_on_ff <= ctrl0_ff.en && !conv_start &&
                            (state_ff == SAS_IDLE || state_ff == SAS_ACQ);
        end
    end

    sas_tad_gen #(
        .RC_CYC(RC_CYC),
        .DLY_CYC(`SAS_INSTR_OSC)
    ) u_tad (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .run(state_ff != SAS_IDLE),
        .clk_sel(ctrl2_ff.clk),
        .tick(tick)
    );

    sas_sar_reg #(
        .W(`SAS_RES_BITS)
    ) u_sar (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .start(sar_start),
        .step(sar_step),
        .cmp_hi(cmp_hi),
        .code(sar_code)
    );

    AST_DONE_CLEARS: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && done_ff && !wr_fire) |=> (!ctrl0_ff.go && flag_ff))
        else $error("Completion did not clear start or set flag");
    AST_RESET_OFF: assert property (@(posedge aclk)
        !aresetn |=> (!ctrl0_ff.en && !ctrl0_ff.go && state_ff == SAS_IDLE))
        else $error("Reset left the module running");
    AST_ABORT_KEEPS: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_ff == SAS_CONV && ce && !ctrl0_ff.go) |=>
        (!done_ff ##1 $stable(res_hi_ff) && $stable(res_lo_ff)))
        else $error("Abort changed the result pair");
    AST_GAP: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_ff == SAS_WAIT && wait_cnt_ff == 2'd0 && ctrl0_ff.en) |=>
        state_ff != SAS_ACQ && state_ff != SAS_CONV)
        else $error("Acquisition started inside the idle gap");
    AST_SWITCH_OPEN: assert property (@(posedge aclk) disable iff (!aresetn)
        state_ff == SAS_CONV |-> !sample_on_ff)
        else $error("Sampling switch closed during conversion");
    AST_NO_ACQ: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && state_ff == SAS_IDLE && live && ctrl2_ff.acq == 3'b000) |=>
        state_ff == SAS_CONV)
        else $error("Zero acquisition did not convert at once");
    AST_ACQ_FOUR: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && state_ff == SAS_IDLE && live && ctrl2_ff.acq == 3'b010) |=>
        acq_cnt_ff == 5'd4)
        else $error("Acquisition 010 did not load four periods");
    AST_CONV_LEN: assert property (@(posedge aclk) disable iff (!aresetn)
        state_ff == SAS_CONV |-> conv_cnt_ff <= 4'd10)
        else $error("Conversion ran past eleven periods");
    AST_DISABLED: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && !ctrl0_ff.en) |=> state_ff == SAS_IDLE)
        else $error("Sequencer ran while disabled");
endmodule

// File: sas_afe_model.sv
// Analog front end model: one input level, hold capacitor, comparator.
// Assumes dac_code is steady whenever the sequencer samples cmp_hi.
`timescale 1ns/100ps
module sas_afe_model (
    // Sequencer side
    input wire logic aclk,
    input wire logic sample_on,
    input wire logic [9:0] dac_code,
    output logic cmp_hi,
    // Bench side
    input wire logic [9:0] vin
);
    logic [9:0] held_ff;
    // Hold capacitor follows the input only while the switch is closed
    always @(posedge aclk) begin
        if (sample_on) begin
            held_ff <= vin;
        end
    end
    // Input sits half a step above its code, so a tie reads as above
    assign cmp_hi = (held_ff >= dac_code);
endmodule

// File: sas_top_tb.sv
// Self-checking bench for the SAR sequencer over AXI4-Lite.
// Assumes the front end model stands in for the analog inputs.
`timescale 1ns/100ps
module sas_top_tb;
    import sas_pkg::*;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic arvalid = 0, rready = 0, cmp_hi, sample_on;
    logic awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata;
    logic [1:0] bresp, rresp, vref_sel;
    logic [9:0] dac_code, vin = 0, pv;
    logic [3:0] chan_sel, pin_cfg;
    logic [33:0] rq[$];
    logic [1:0] bq[$];
    logic [15:0] lf = 16'h4d5e;
    logic [2:0] sels[8] = '{0, 4, 1, 5, 2, 6, 3, 7};
    int tps[8] = '{2, 4, 8, 16, 32, 64, 8, 8};
    int acq[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
    int fail_count = 0, num_checks = 0, cyc = 0, t0, t1;
    sas_top #(.RC_CYC(8)) uut (.aclk(aclk), .aresetn(aresetn), .ce(1'h1),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
        .wstrb(4'hf), .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata),
        .rresp(rresp), .cmp_hi(cmp_hi), .sample_on(sample_on),
        .dac_code(dac_code), .chan_sel(chan_sel), .pin_cfg(pin_cfg),
        .vref_sel(vref_sel));
    sas_afe_model afe (.aclk(aclk), .sample_on(sample_on),
        .dac_code(dac_code), .cmp_hi(cmp_hi), .vin(vin));
    always #5 aclk = ~aclk;
    function automatic logic [15:0] nx(logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task automatic chk(string n, logic [33:0] lo, logic [33:0] hi,
            logic [33:0] v);
        num_checks++;
        if ((v >= lo && v <= hi) !== 1'b1) begin
            fail_count++;
            $display("ERROR %s expected %0h..%0h seen %0h", n, lo, hi, v);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] r);
        bq.push_back(r);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while (!((awready || !awvalid) && (wready || !wvalid)));
        do @(posedge aclk); while (bvalid !== 1'b1);
        bready <= 0;
    endtask
    task automatic rd(logic [7:0] a, logic [33:0] e);
        rq.push_back(e);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rready <= 0;
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (rvalid && rready) begin
            chk("rdata", rq[0], rq[0], {rresp, rdata});
            void'(rq.pop_front());
        end
        if (bvalid && bready) begin
            chk("bresp", bq[0], bq[0], bresp);
            void'(bq.pop_front());
        end
        if (cyc == 40000) begin
            fail_count++;
            print_verdict();
        end
    end
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        rd(8'h00, 34'h0);
        rd(8'h08, 34'h0);
        rd(8'h14, 34'h0);
        rd(8'h18, 34'h200000000);
        wr(8'h1c, 32'h0, 2'h2);
        wr(8'h04, 32'h39, 2'h0);
        wr(8'h00, 32'h2, 2'h0);
        rd(8'h00, 34'h0);
        wr(8'h00, 32'h15, 2'h0);
        chk("vref", 2'h3, 2'h3, vref_sel);
        chk("pins", 4'h9, 4'h9, pin_cfg);
        chk("chan", 4'h5, 4'h5, chan_sel);
        $display("register test done");
        for (int i = 0; i < 8; i++) begin
            lf = nx(lf);
            vin <= lf[9:0];
            wr(8'h08, {24'h0, i[0], 1'b0, i[2:0], sels[i]}, 2'h0);
            wr(8'h00, 32'h17, 2'h0);
            t0 = cyc;
            while (sample_on !== 1'b0) @(posedge aclk);
            t1 = cyc;
            chk("acq", acq[i] * tps[i], acq[i] * tps[i] + 8, t1 - t0 + 2);
            while (sample_on !== 1'b1) @(posedge aclk);
            chk("conv", 13 * tps[i], 13 * tps[i] + 8, cyc - t1);
            rd(8'h00, 34'h15);
            rd(8'h14, 34'h1);
            rd(8'h0c, i[0] ? vin[9:8] : vin[9:2]);
            rd(8'h10, i[0] ? vin[7:0] : {vin[1:0], 6'h0});
            wr(8'h14, 32'h1, 2'h0);
            rd(8'h14, 34'h0);
            $display("conversion test %0d done", i);
        end
        pv = vin;
        vin <= ~pv;
        wr(8'h08, 32'h86, 2'h0);
        wr(8'h00, 32'h17, 2'h0);
        repeat (100) @(posedge aclk);
        wr(8'h00, 32'h15, 2'h0);
        rd(8'h00, 34'h15);
        rd(8'h14, 34'h0);
        rd(8'h10, pv[7:0]);
        $display("abort test done");
        print_verdict();
    end
endmodule
